// ---- rtl/flash_bulk_eraser.sv ----
// Host sequencer for bulk erase of a command-register flash
`timescale 1ns/100ps
module flash_bulk_eraser
   import flash_erase_pkg::*;
#(
   parameter int AW = ADDR_W,
   parameter int ERASE_CYC = ERASE_PULSE_CYC,
   parameter int MAX_ERASE = MAX_ERASE_PULSES
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic start,
   output logic [AW-1:0] flash_addr,
   output logic [7:0] flash_dq_out,
   output logic flash_dq_oe,
   input wire logic [7:0] flash_dq_in,
   output logic flash_ce_n,
   output logic flash_we_n,
   output logic flash_oe_n,
   output logic program_supply_high_level_en,
   output logic busy,
   output logic done,
   output logic erase_ok,
   output logic erase_fail,
   output logic [TALLY_W-1:0] erase_pulse_tally
);
   flash_cycle_if #(.AW(AW)) bus ();

   seq_state_e state_reg, state_next;
   logic [AW-1:0] addr_reg, addr_next;
   logic [TALLY_W-1:0] tally_reg, tally_next;
   logic [PPULSE_W-1:0] ppulse_reg, ppulse_next;
   logic [TMR_W-1:0] timer_reg, timer_next;
   logic pend_reg, pend_next, req_reg, req_next, wr_reg, wr_next;
   logic [7:0] wdata_reg, wdata_next;
   logic vpp_reg, vpp_next, busy_reg, busy_next, done_reg, done_next;
   logic ok_reg, ok_next, fail_reg, fail_next;
   logic is_bus, op_wr, cyc_done, last_addr;
   logic [7:0] op_data;

   assign cyc_done = pend_reg && bus.done;
   assign last_addr = (addr_reg == {AW{1'b1}});

   // Which bus cycle each state issues
   always_comb begin
      is_bus = 1'b1;
      op_wr = 1'b1;
      op_data = CMD_READ;
      case (state_reg)
         ST_READ_CMD: op_data = CMD_READ;
         ST_BLANK_RD: op_wr = 1'b0;
         ST_PGM_SETUP: op_data = CMD_PSETUP;
         ST_PGM_WR: op_data = BYTE_CHARGED;
         ST_PGM_VFY: op_data = CMD_PVERIFY;
         ST_PGM_RD: op_wr = 1'b0;
         ST_ERS_SETUP: op_data = CMD_ERASE;
         ST_ERS_GO: op_data = CMD_ERASE;
         ST_EV_CMD: op_data = CMD_EVERIFY;
         ST_EV_RD: op_wr = 1'b0;
         ST_RST_CMD: op_data = CMD_RESET;
         default: is_bus = 1'b0;
      endcase
   end

   always_comb begin
      state_next = state_reg;
      addr_next = addr_reg;
      tally_next = tally_reg;
      ppulse_next = ppulse_reg;
      timer_next = timer_reg;
      pend_next = pend_reg;
      req_next = 1'b0;
      wr_next = wr_reg;
      wdata_next = wdata_reg;
      vpp_next = vpp_reg;
      busy_next = busy_reg;
      done_next = 1'b0;
      ok_next = ok_reg;
      fail_next = fail_reg;
      if (is_bus && !pend_reg) begin
         req_next = 1'b1;
         pend_next = 1'b1;
         wr_next = op_wr;
         wdata_next = op_data;
      end
      if (cyc_done) begin
         pend_next = 1'b0;
      end
      case (state_reg)
         ST_IDLE: begin
            if (start) begin
               busy_next = 1'b1;
               ok_next = 1'b0;
               fail_next = 1'b0;
               addr_next = '0;
               tally_next = '0;
               vpp_next = 1'b1;
               timer_next = TMR_W'(VPP_RAMP_CYC - 1);
               state_next = ST_VPP_UP;
            end
         end
         ST_VPP_UP, ST_PGM_WAIT, ST_PGM_SETTLE, ST_ERS_WAIT, ST_EV_SETTLE, ST_VPP_DOWN: begin
            // Every timed wait hands over to the state declared right after it
            timer_next = timer_reg - 1'b1;
            if (timer_reg == '0) begin
               state_next = seq_state_e'(state_reg + 1'b1);
            end
         end
         ST_READ_CMD, ST_PGM_SETUP, ST_ERS_SETUP: begin
            if (cyc_done) begin
               state_next = seq_state_e'(state_reg + 1'b1);
            end
         end
         ST_BLANK_RD: begin
            if (cyc_done) begin
               if (bus.rdata != BYTE_ERASED) begin
                  addr_next = '0;
                  ppulse_next = '0;
                  state_next = ST_PGM_SETUP;
               end else if (last_addr) begin
                  ok_next = 1'b1;
                  state_next = ST_RST_CMD;
               end else begin
                  addr_next = addr_reg + 1'b1;
               end
            end
         end
         ST_PGM_WR: begin
            if (cyc_done) begin
               ppulse_next = ppulse_reg + 1'b1;
               timer_next = TMR_W'(PROG_PULSE_CYC - 1);
               state_next = ST_PGM_WAIT;
            end
         end
         ST_PGM_VFY: begin
            if (cyc_done) begin
               timer_next = TMR_W'(SETTLE_CYC - 1);
               state_next = ST_PGM_SETTLE;
            end
         end
         ST_PGM_RD: begin
            if (cyc_done) begin
               if (bus.rdata == BYTE_CHARGED) begin
                  ppulse_next = '0;
                  if (last_addr) begin
                     addr_next = '0;
                     tally_next = '0;
                     state_next = ST_ERS_SETUP;
                  end else begin
                     addr_next = addr_reg + 1'b1;
                     state_next = ST_PGM_SETUP;
                  end
               end else if (ppulse_reg == PPULSE_W'(MAX_PROG_PULSES)) begin
                  // A byte that will not charge cannot be erased reliably
                  fail_next = 1'b1;
                  state_next = ST_RST_CMD;
               end else begin
                  state_next = ST_PGM_SETUP;
               end
            end
         end
         ST_ERS_GO: begin
            if (cyc_done) begin
               // Timer starts once the second strobe has risen
               tally_next = tally_reg + 1'b1;
               timer_next = TMR_W'(ERASE_CYC - 1);
               state_next = ST_ERS_WAIT;
            end
         end
         ST_EV_CMD: begin
            if (cyc_done) begin
               timer_next = TMR_W'(SETTLE_CYC - 1);
               state_next = ST_EV_SETTLE;
            end
         end
         ST_EV_RD: begin
            if (cyc_done) begin
               if (bus.rdata == BYTE_ERASED) begin
                  if (last_addr) begin
                     ok_next = 1'b1;
                     state_next = ST_RST_CMD;
                  end else begin
                     addr_next = addr_reg + 1'b1;
                     state_next = ST_EV_CMD;
                  end
               end else if (tally_reg == TALLY_W'(MAX_ERASE)) begin
                  fail_next = 1'b1;
                  state_next = ST_RST_CMD;
               end else begin
                  // Failing address is kept so verification resumes there
                  state_next = ST_ERS_SETUP;
               end
            end
         end
         ST_RST_CMD: begin
            if (cyc_done) begin
               timer_next = TMR_W'(VPP_RAMP_CYC - 1);
               vpp_next = 1'b0;
               state_next = ST_VPP_DOWN;
            end
         end
         ST_DONE: begin
            busy_next = 1'b0;
            done_next = 1'b1;
            state_next = ST_IDLE;
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= ST_IDLE;
         addr_reg <= '0;
         tally_reg <= '0;
         ppulse_reg <= '0;
         timer_reg <= '0;
         pend_reg <= 1'b0;
         req_reg <= 1'b0;
         wr_reg <= 1'b0;
         wdata_reg <= CMD_READ;
         vpp_reg <= 1'b0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         ok_reg <= 1'b0;
         fail_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         addr_reg <= addr_next;
         tally_reg <= tally_next;
         ppulse_reg <= ppulse_next;
         timer_reg <= timer_next;
         pend_reg <= pend_next;
         req_reg <= req_next;
         wr_reg <= wr_next;
         wdata_reg <= wdata_next;
         vpp_reg <= vpp_next;
         busy_reg <= busy_next;
         done_reg <= done_next;
         ok_reg <= ok_next;
         fail_reg <= fail_next;
      end
   end

   assign bus.req = req_reg;
   assign bus.wr = wr_reg;
   assign bus.addr = addr_reg;
   assign bus.wdata = wdata_reg;
   assign program_supply_high_level_en = vpp_reg;
   assign busy = busy_reg;
   assign done = done_reg;
   assign erase_ok = ok_reg;
   assign erase_fail = fail_reg;
   assign erase_pulse_tally = tally_reg;

   flash_cycle_engine #(.AW(AW)) u_engine (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .bus(bus),
      .flash_addr(flash_addr),
      .flash_dq_out(flash_dq_out),
      .flash_dq_oe(flash_dq_oe),
      .flash_dq_in(flash_dq_in),
      .flash_ce_n(flash_ce_n),
      .flash_we_n(flash_we_n),
      .flash_oe_n(flash_oe_n)
   );

   // Helper: cycles spent in the current state, read only by assertions
   logic [TMR_W-1:0] stay_cnt;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         stay_cnt <= '0;
      end else begin
         stay_cnt <= (state_next != state_reg) ? '0 : stay_cnt + 1'b1;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   sequence s_setup_written;
      state_reg == ST_ERS_SETUP && cyc_done;
   endsequence
   sequence s_verify_failed;
      state_reg == ST_EV_RD && cyc_done && bus.rdata != BYTE_ERASED;
   endsequence

   a_erase_pair: assert property (s_setup_written |=> state_reg == ST_ERS_GO ##1 req_reg && wdata_reg == CMD_ERASE)
      else $error("second erase write missing");
   a_erase_wait_len: assert property ((state_reg == ST_ERS_WAIT && state_next != ST_ERS_WAIT)
      |-> stay_cnt == TMR_W'(ERASE_CYC - 1)) else $error("erase pulse timer wrong length");
   a_settle_len: assert property ((state_reg == ST_EV_SETTLE && state_next != ST_EV_SETTLE)
      |-> stay_cnt == TMR_W'(SETTLE_CYC - 1)) else $error("verify settle wait wrong length");
   a_tally_cap: assert property (tally_reg <= TALLY_W'(MAX_ERASE))
      else $error("erase pulse tally above limit");
   a_fail_reerase: assert property ((s_verify_failed and tally_reg < TALLY_W'(MAX_ERASE))
      |=> state_reg == ST_ERS_SETUP && addr_reg == $past(addr_reg)) else $error("failed byte not re-erased");
   a_limit_abort: assert property ((s_verify_failed and tally_reg == TALLY_W'(MAX_ERASE))
      |=> state_reg == ST_RST_CMD && fail_reg) else $error("pulse limit not reported");
   a_verify_start: assert property ((state_reg == ST_PGM_RD && state_next == ST_ERS_SETUP)
      |=> addr_reg == '0 && tally_reg == '0) else $error("verify does not start at zero");
   a_vpp_held: assert property ((state_reg inside {[ST_READ_CMD:ST_RST_CMD]}) |-> vpp_reg)
      else $error("high supply dropped mid sequence");
   a_verify_cmd: assert property ((state_reg == ST_EV_CMD && req_reg)
      |-> wr_reg && wdata_reg == CMD_EVERIFY) else $error("verify command data wrong");
   a_blank_skip: assert property ((state_reg == ST_BLANK_RD && cyc_done && last_addr
      && bus.rdata == BYTE_ERASED) |=> state_reg == ST_RST_CMD && ok_reg && tally_reg == '0)
      else $error("blank device not skipped");
   a_reset_last: assert property ((state_reg == ST_RST_CMD && req_reg) |-> wdata_reg == CMD_RESET)
      else $error("reset command data wrong");
endmodule

// ---- inc/flash_erase_pkg.sv ----
// Constants, commands and state types for the bulk erase controller
package flash_erase_pkg;
   localparam int CLK_PERIOD_NS = 10;
   // erase_pulse_duration: host timer for one bulk erase pulse
   localparam int ERASE_PULSE_NS = 10_000_000;
   localparam int ERASE_PULSE_CYC = (ERASE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PROG_PULSE_NS = 10_000;
   localparam int PROG_PULSE_CYC = (PROG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_NS = 6_000;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int VPP_RAMP_NS = 1_000;
   localparam int VPP_RAMP_CYC = (VPP_RAMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WE_LOW_NS = 100;
   localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_ACC_NS = 150;
   localparam int READ_ACC_CYC = (READ_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MAX_ERASE_PULSES = 1000;
   localparam int MAX_PROG_PULSES = 25;
   localparam int ADDR_W = 18;
   localparam int TALLY_W = 10;
   localparam int PPULSE_W = 5;
   localparam int TMR_W = 20;
   localparam int ECNT_W = 8;
   localparam logic [7:0] CMD_READ = 8'h00;
   localparam logic [7:0] CMD_ERASE = 8'h20;
   localparam logic [7:0] CMD_PSETUP = 8'h40;
   localparam logic [7:0] CMD_EVERIFY = 8'ha0;
   localparam logic [7:0] CMD_PVERIFY = 8'hc0;
   localparam logic [7:0] CMD_RESET = 8'hff;
   localparam logic [7:0] BYTE_ERASED = 8'hff;
   localparam logic [7:0] BYTE_CHARGED = 8'h00;
   localparam logic [7:0] DQ_RST = 8'h00;

   typedef enum logic [4:0] {
      ST_IDLE, ST_VPP_UP, ST_READ_CMD, ST_BLANK_RD, ST_PGM_SETUP, ST_PGM_WR, ST_PGM_WAIT,
      ST_PGM_VFY, ST_PGM_SETTLE, ST_PGM_RD, ST_ERS_SETUP, ST_ERS_GO, ST_ERS_WAIT, ST_EV_CMD,
      ST_EV_SETTLE, ST_EV_RD, ST_RST_CMD, ST_VPP_DOWN, ST_DONE
   } seq_state_e;

   typedef enum logic [2:0] {EG_IDLE, EG_SETUP, EG_STROBE, EG_HOLD, EG_READ} eng_state_e;
endpackage

// ---- inc/flash_cycle_if.sv ----
// Bus cycle request and answer between sequencer and pin engine
`timescale 1ns/100ps
interface flash_cycle_if #(parameter int AW = 18);
   logic req;
   logic wr;
   logic [AW-1:0] addr;
   logic [7:0] wdata;
   logic done;
   logic [7:0] rdata;
   modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
   modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// ---- rtl/flash_cycle_engine.sv ----
// Pin engine: one flash write or read bus cycle per request
`timescale 1ns/100ps
module flash_cycle_engine
   import flash_erase_pkg::*;
#(
   parameter int AW = ADDR_W
) (
   input wire logic ref_clk,
   input wire logic rstn,
   flash_cycle_if.eng bus,
   output logic [AW-1:0] flash_addr,
   output logic [7:0] flash_dq_out,
   output logic flash_dq_oe,
   input wire logic [7:0] flash_dq_in,
   output logic flash_ce_n,
   output logic flash_we_n,
   output logic flash_oe_n
);
   eng_state_e eng_reg, eng_next;
   logic [ECNT_W-1:0] cnt_reg, cnt_next;
   logic [AW-1:0] addr_reg, addr_next;
   logic [7:0] dout_reg, dout_next, rdata_reg, rdata_next;
   logic oe_reg, oe_next, ce_n_reg, ce_n_next, we_n_reg, we_n_next, oe_n_reg, oe_n_next;
   logic done_reg, done_next;
   logic [7:0] dq_meta_reg, dq_sync_reg;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         dq_meta_reg <= DQ_RST;
         dq_sync_reg <= DQ_RST;
      end else begin
         dq_meta_reg <= flash_dq_in;
         dq_sync_reg <= dq_meta_reg;
      end
   end

   always_comb begin
      eng_next = eng_reg;
      cnt_next = cnt_reg;
      addr_next = addr_reg;
      dout_next = dout_reg;
      rdata_next = rdata_reg;
      oe_next = oe_reg;
      ce_n_next = ce_n_reg;
      we_n_next = we_n_reg;
      oe_n_next = oe_n_reg;
      done_next = 1'b0;
      case (eng_reg)
         EG_IDLE: begin
            if (bus.req) begin
               addr_next = bus.addr;
               dout_next = bus.wdata;
               cnt_next = '0;
               if (bus.wr) begin
                  oe_next = 1'b1;
                  eng_next = EG_SETUP;
               end else begin
                  ce_n_next = 1'b0;
                  oe_n_next = 1'b0;
                  eng_next = EG_READ;
               end
            end
         end
         EG_SETUP: begin
            // Output enable stays high so the write is accepted
            ce_n_next = 1'b0;
            we_n_next = 1'b0;
            eng_next = EG_STROBE;
         end
         EG_STROBE: begin
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == ECNT_W'(WE_LOW_CYC - 1)) begin
               we_n_next = 1'b1;
               eng_next = EG_HOLD;
            end
         end
         EG_HOLD: begin
            // Data still driven while strobe rises, released a cycle later
            ce_n_next = 1'b1;
            oe_next = 1'b0;
            done_next = 1'b1;
            eng_next = EG_IDLE;
         end
         EG_READ: begin
            cnt_next = cnt_reg + 1'b1;
            // Two extra cycles cover the pin synchroniser
            if (cnt_reg == ECNT_W'(READ_ACC_CYC + 1)) begin
               rdata_next = dq_sync_reg;
               ce_n_next = 1'b1;
               oe_n_next = 1'b1;
               done_next = 1'b1;
               eng_next = EG_IDLE;
            end
         end
         default: eng_next = EG_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         eng_reg <= EG_IDLE;
         cnt_reg <= '0;
         addr_reg <= '0;
         dout_reg <= DQ_RST;
         rdata_reg <= DQ_RST;
         oe_reg <= 1'b0;
         ce_n_reg <= 1'b1;
         we_n_reg <= 1'b1;
         oe_n_reg <= 1'b1;
         done_reg <= 1'b0;
      end else begin
         eng_reg <= eng_next;
         cnt_reg <= cnt_next;
         addr_reg <= addr_next;
         dout_reg <= dout_next;
         rdata_reg <= rdata_next;
         oe_reg <= oe_next;
         ce_n_reg <= ce_n_next;
         we_n_reg <= we_n_next;
         oe_n_reg <= oe_n_next;
         done_reg <= done_next;
      end
   end

   assign bus.done = done_reg;
   assign bus.rdata = rdata_reg;
   assign flash_addr = addr_reg;
   assign flash_dq_out = dout_reg;
   assign flash_dq_oe = oe_reg;
   assign flash_ce_n = ce_n_reg;
   assign flash_we_n = we_n_reg;
   assign flash_oe_n = oe_n_reg;

   a_write_strobe_ok: assert property (@(posedge ref_clk) disable iff (!rstn)
      !we_n_reg |-> (oe_n_reg && !ce_n_reg && oe_reg)) else $error("write strobe with bad control pins");
endmodule

// ---- dv/flash_dev_model.sv ----
// Behavioural model of the bulk-erase flash device at the far side of the pins
`timescale 1ns/100ps
module flash_dev_model
   import flash_erase_pkg::*;
#(
   parameter int AW = 3
) (
   input wire logic [AW-1:0] addr,
   input wire logic [7:0] dq_wr,
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic vpp,
   output logic [7:0] dq_rd
);
   localparam logic [7:0] ERASE_RUN = 8'h2e;
   localparam logic [7:0] PROG_RUN = 8'h4e;
   logic [7:0] mem [2**AW];
   int need [2**AW];
   int pulses = 0;
   logic [7:0] cmd = CMD_READ;
   logic [7:0] last_cmd = CMD_READ;
   logic [AW-1:0] lat = '0;
   logic [AW-1:0] vaddr = '0;
   logic erasing = 1'b0;
   initial dq_rd = 8'h5a;
   always @(negedge vpp) begin
      cmd = CMD_READ;
      erasing = 1'b0;
   end
   // Address is taken on the later of the two falling edges, so a tie between them cannot lose it
   always @(negedge we_n or negedge ce_n)
      if (!we_n && !ce_n && oe_n) lat = addr;
   always @(posedge we_n) begin
      if (vpp && !ce_n && oe_n) begin
         // Pulse length is not timed here, so a late host is not caught by this model
         if (erasing) begin
            erasing = 1'b0;
            pulses++;
            foreach (mem[i]) if (pulses >= need[i]) mem[i] = BYTE_ERASED;
         end
         if (cmd == CMD_ERASE && dq_wr == CMD_ERASE) begin
            erasing = 1'b1;
            cmd = ERASE_RUN;
         end else if (cmd == CMD_PSETUP) begin
            mem[lat] = mem[lat] & dq_wr;
            vaddr = lat;
            pulses = 0;
            cmd = PROG_RUN;
         end else begin
            cmd = dq_wr;
            if (dq_wr == CMD_EVERIFY) vaddr = lat;
         end
         last_cmd = dq_wr;
      end
   end
   // A released bus keeps changing, so stale data never passes for a read
   always @(ce_n or oe_n or addr or cmd or vaddr) begin
      if (!ce_n && !oe_n) dq_rd = (cmd == CMD_EVERIFY || cmd == CMD_PVERIFY) ? mem[vaddr] : mem[addr];
      else dq_rd = ~dq_rd;
   end
endmodule

// ---- dv/bulk_flash_erase_sequence_tb.sv ----
// Self-checking testbench for the bulk erase controller
`timescale 1ns/100ps
module bulk_flash_erase_sequence_tb;
   import flash_erase_pkg::*;
   localparam int AW = 3;
   localparam int ME = 3;
   logic ref_clk, rstn, start, flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n;
   logic vpp_en, busy, done, erase_ok, erase_fail;
   logic [AW-1:0] flash_addr;
   logic [7:0] flash_dq_out, flash_dq_in;
   logic [TALLY_W-1:0] erase_pulse_tally;
   int miscompares = 0;
   int cmp_count = 0;
   int seed = 7;
   int cyc = 0;
   flash_bulk_eraser #(.AW(AW), .ERASE_CYC(50), .MAX_ERASE(ME)) DUT (.ref_clk(ref_clk), .rstn(rstn),
      .start(start), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
      .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
      .program_supply_high_level_en(vpp_en), .busy(busy), .done(done), .erase_ok(erase_ok),
      .erase_fail(erase_fail), .erase_pulse_tally(erase_pulse_tally));
   flash_dev_model #(.AW(AW)) partner (.addr(flash_addr), .dq_wr(flash_dq_out), .ce_n(flash_ce_n),
      .we_n(flash_we_n), .oe_n(flash_oe_n), .vpp(vpp_en), .dq_rd(flash_dq_in));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 80000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   // A read cycle must never overlap a write strobe or host-driven data
   always @(negedge ref_clk)
      if (rstn && !flash_oe_n) check("read_pins", {flash_we_n, flash_dq_oe}, 32'h2);
   // Mode 0 blank device, 1 slowest byte at the pulse limit, 2 one over it, 3 random
   task automatic run(input int mode);
      int mx;
      bit blank;
      mx = 0;
      blank = 1'b1;
      foreach (partner.mem[i]) begin
         partner.mem[i] = (mode == 0) ? BYTE_ERASED : 8'($random(seed));
         partner.need[i] = 1 + int'($unsigned($random(seed)) % ME);
         if (i == 5 && (mode == 1 || mode == 2)) partner.need[i] = ME + mode - 1;
         if (partner.mem[i] !== BYTE_ERASED) blank = 1'b0;
         if (partner.need[i] > mx) mx = partner.need[i];
      end
      @(negedge ref_clk);
      start = 1'b1;
      @(negedge ref_clk);
      start = 1'b0;
      @(negedge ref_clk);
      check("busy_run", busy, 1);
      for (int k = 0; k < 30000 && done !== 1'b1; k++) @(negedge ref_clk);
      check("done", done, 1);
      check("busy_end", busy, 0);
      check("tally", erase_pulse_tally, blank ? 0 : (mx < ME ? mx : ME));
      check("ok", erase_ok, blank || mx <= ME);
      check("fail", erase_fail, !blank && mx > ME);
      check("last_cmd", partner.last_cmd, CMD_RESET);
      check("supply", vpp_en, 0);
      if (erase_ok === 1'b1) foreach (partner.mem[i]) check("byte", partner.mem[i], BYTE_ERASED);
      if (erase_fail === 1'b1) check("charged", partner.mem[5], BYTE_CHARGED);
      @(negedge ref_clk);
      check("done_pulse", done, 0);
   endtask
   initial begin
      rstn = 1'b0;
      start = 1'b0;
      repeat (3) @(negedge ref_clk);
      rstn = 1'b1;
      for (int m = 0; m < 3; m++) run(m);
      // Abort in mid-run: strobes, data enable, supply, busy and tally must fall back to idle levels at once
      start = 1'b1;
      repeat (400) @(negedge ref_clk);
      start = 1'b0;
      rstn = 1'b0;
      @(negedge ref_clk);
      check("rst_pins", {busy, flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe, vpp_en, erase_pulse_tally},
         {1'b0, 3'b111, 2'b00, 10'h0});
      rstn = 1'b1;
      run(3);
      tally_and_finish();
   end
endmodule
